// [hw/tcdma_top.sv]
// three-channel dma engine sharing the processor bus, with apb register slave
`timescale 1ns/1ps
module tcdma_top import tcdma_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register bus
   input wire tcdma_apb_req_s apb_req,
   output tcdma_apb_rsp_s apb_rsp,
   // shared internal bus
   output tcdma_bus_s bus_out,
   input wire logic [7:0] bus_rdata,
   // service requests from peripherals
   input wire logic [NUM_CH-1:0] svc_req,
   // processor status
   input wire logic cpu_wait,
   input wire logic cpu_stop,
   input wire logic stop_exit_reset,
   input wire logic cpu_irq_req,
   output logic cpu_irq_allow,
   // break module
   input wire logic brk_active,
   input wire logic [15:0] brk_addr,
   output logic brk_hit,
   // per channel interrupt requests
   output logic [NUM_CH-1:0] chan_irq
);

   typedef struct packed {
      logic [NUM_CH-1:0] te;
      logic [NUM_CH-1:0] ie;
      logic [1:0] bw;
      logic [NUM_CH-1:0] done;
      logic [NUM_CH-1:0] arm;
      logic [NUM_CH-1:0] loop;
      logic wre;
      logic prio;
      logic bce;
      logic [NUM_CH-1:0] swi;
      logic [NUM_CH-1:0][15:0] src;
      logic [NUM_CH-1:0][15:0] dst;
      logic [NUM_CH-1:0][4:0] ctl;
      logic [NUM_CH-1:0][7:0] blen;
      logic [NUM_CH-1:0][7:0] cnt;
      logic [NUM_CH-1:0] busy;
      logic susp;
      tcdma_state_e st;
      logic [1:0] ch;
      logic [2:0] gap;
      logic [1:0] stall;
      tcdma_apb_rsp_s rsp;
      tcdma_bus_s bus;
      logic brk_hit;
      logic [NUM_CH-1:0] irq;
      logic irq_allow;
   } tcdma_regs_s;

   tcdma_regs_s state_q;
   tcdma_regs_s state_d;

   // static side in word mode walks base, base+1; moving sides add or subtract the count
   function automatic logic [15:0] calc_addr(input logic [15:0] base, input logic [1:0] mode,
                                             input logic [7:0] cnt, input logic word);
      logic [15:0] res;
      res = base;
      unique case (mode)
         MODE_INC: res = base + {8'h00, cnt};
         MODE_DEC: res = base - {8'h00, cnt};
         default: res = base + {15'h0000, word & cnt[0]};
      endcase
      return res;
   endfunction

   function automatic logic [2:0] bw_gap(input logic [1:0] bw);
      logic [2:0] g;
      g = GAP_BW3;
      unique case (bw)
         2'h0: g = GAP_BW0;
         2'h1: g = GAP_BW1;
         2'h2: g = GAP_BW2;
         2'h3: g = GAP_BW3;
      endcase
      return g;
   endfunction

   logic [NUM_CH-1:0] runnable;
   logic any_run;
   logic [1:0] pick;
   logic low_power;
   logic hold;
   logic setup;
   logic wr_acc;
   logic rd_setup;
   logic ch_hit;
   logic [1:0] wch;
   logic flag_free;
   logic [7:0] cnt_nx;
   logic blk_end;
   logic word_mid;
   logic [1:0] busy_cnt;
   logic [15:0] src_a;
   logic [15:0] dst_a;
   logic word_go;
   logic burst_go;
   logic [15:0] next_src;

   always_comb begin
      runnable = state_q.busy & state_q.te;
      any_run = |runnable;
      pick = 2'h0;
      // lowest channel number wins; arbitration runs even while the bus is held
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (runnable[i]) begin
            pick = i[1:0];
         end
      end
      low_power = cpu_stop || (cpu_wait && !state_q.wre);
      hold = low_power || brk_active || (state_q.stall != 2'h0);
      setup = apb_req.psel && !apb_req.penable;
      wr_acc = apb_req.psel && apb_req.penable && state_q.rsp.pready && apb_req.pwrite;
      rd_setup = setup && !apb_req.pwrite;
      ch_hit = (apb_req.paddr >= A_CH_FIRST) && (apb_req.paddr <= A_CH_LAST);
      wch = apb_req.paddr[5:4] - 2'h1;
      flag_free = !brk_active || state_q.bce;
      cnt_nx = state_q.cnt[state_q.ch] + 8'h01;
      blk_end = (cnt_nx == state_q.blen[state_q.ch]);
      word_mid = state_q.ctl[state_q.ch][CC_WORD_BIT] && cnt_nx[0] && !blk_end;
      busy_cnt = 2'h0;
      for (int i = 0; i < NUM_CH; i++) begin
         busy_cnt = busy_cnt + {1'b0, runnable[i]};
      end
      src_a = calc_addr(state_q.src[pick], state_q.ctl[pick][CC_SRC_LSB +: 2], state_q.cnt[pick],
                        state_q.ctl[pick][CC_WORD_BIT]);
      dst_a = calc_addr(state_q.dst[state_q.ch], state_q.ctl[state_q.ch][CC_DST_LSB +: 2],
                        state_q.cnt[state_q.ch], state_q.ctl[state_q.ch][CC_WORD_BIT]);
      // second byte of a word follows at once; the channel keeps the bus for it
      word_go = word_mid && !brk_active && !low_power && state_q.te[state_q.ch];
      // full bandwidth keeps the bus only while no higher channel waits and nothing holds it,
      // so an interrupt with priority clear still gets in at the next byte boundary
      burst_go = (bw_gap(state_q.bw) == GAP_BW3) && !blk_end && !hold && runnable[state_q.ch] &&
                 (pick == state_q.ch) && !(cpu_irq_req && !state_q.prio);
      next_src = calc_addr(state_q.src[state_q.ch], state_q.ctl[state_q.ch][CC_SRC_LSB +: 2], cnt_nx,
                           state_q.ctl[state_q.ch][CC_WORD_BIT]);
   end

   always_comb begin
      state_d = state_q;
      state_d.rsp.pready = 1'b0;
      state_d.rsp.pslverr = 1'b0;
      state_d.bus.rd = 1'b0;
      state_d.bus.wr = 1'b0;
      state_d.brk_hit = 1'b0;

      // register reads are prepared in the setup cycle so the answer comes from flops
      if (setup) begin
         state_d.rsp.pready = 1'b1;
         state_d.rsp.prdata = 32'h0000_0000;
         if (apb_req.paddr == A_GCTRL) begin
            state_d.rsp.prdata[7:0] = {state_q.bw, state_q.ie, state_q.te};
         end else if (apb_req.paddr == A_STAT) begin
            state_d.rsp.prdata[7:0] = {state_q.prio, state_q.wre, state_q.loop, state_q.done};
         end else if (apb_req.paddr == A_SWINIT) begin
            state_d.rsp.prdata[NUM_CH-1:0] = state_q.swi;
         end else if (apb_req.paddr == A_BRKCTL) begin
            state_d.rsp.prdata[BC_BCE_BIT] = state_q.bce;
         end else if (ch_hit && apb_req.paddr[1:0] == 2'h0) begin
            unique case (apb_req.paddr[3:2])
               CH_SRC: state_d.rsp.prdata[15:0] = state_q.src[wch];
               CH_DST: state_d.rsp.prdata[15:0] = state_q.dst[wch];
               CH_CTL: state_d.rsp.prdata[15:0] = {state_q.cnt[wch], 3'h0, state_q.ctl[wch]};
               CH_BLEN: state_d.rsp.prdata[7:0] = state_q.blen[wch];
            endcase
         end else begin
            state_d.rsp.pslverr = 1'b1;
         end
         // first step of the flag clear; not armed by reads during a protected break
         if (rd_setup && apb_req.paddr == A_STAT && flag_free) begin
            state_d.arm = state_q.arm | state_q.done;
         end
      end

      // register writes; global ones never stall the engine, only channel ones do while a channel is busy
      if (wr_acc) begin
         if (apb_req.paddr == A_GCTRL) begin
            state_d.te = apb_req.pwdata[GC_TE_LSB +: NUM_CH];
            state_d.ie = apb_req.pwdata[GC_IE_LSB +: NUM_CH];
            state_d.bw = apb_req.pwdata[GC_BW_LSB +: 2];
         end else if (apb_req.paddr == A_STAT) begin
            state_d.loop = apb_req.pwdata[ST_LOOP_LSB +: NUM_CH];
            state_d.wre = apb_req.pwdata[ST_WRE_BIT];
            state_d.prio = apb_req.pwdata[ST_PRIO_BIT];
            if (flag_free) begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (state_q.arm[i] && !apb_req.pwdata[ST_DONE_LSB + i]) begin
                     state_d.done[i] = 1'b0;
                     state_d.arm[i] = 1'b0;
                  end
               end
            end
         end else if (apb_req.paddr == A_SWINIT) begin
            state_d.swi = apb_req.pwdata[NUM_CH-1:0];
         end else if (apb_req.paddr == A_BRKCTL) begin
            state_d.bce = apb_req.pwdata[BC_BCE_BIT];
         end else if (ch_hit && apb_req.paddr[1:0] == 2'h0) begin
            unique case (apb_req.paddr[3:2])
               CH_SRC: state_d.src[wch] = apb_req.pwdata[15:0];
               CH_DST: state_d.dst[wch] = apb_req.pwdata[15:0];
               CH_CTL: state_d.ctl[wch] = apb_req.pwdata[4:0];
               CH_BLEN: state_d.blen[wch] = apb_req.pwdata[7:0];
            endcase
            if (|state_q.busy) begin
               // a control write to a disabled channel skips the suspend step, so it costs one cycle less
               if (apb_req.paddr[3:2] == CH_CTL && !state_q.te[wch]) begin
                  state_d.stall = LAT_DISABLED;
               end else begin
                  state_d.stall = LAT_ENABLED;
               end
            end
         end
      end

      // enabled channels with a request open a block
      for (int i = 0; i < NUM_CH; i++) begin
         if (state_q.te[i] && (svc_req[i] || state_q.swi[i])) begin
            state_d.busy[i] = 1'b1;
         end
      end

      // low-power suspension and its exit
      if (low_power && (|state_q.busy)) begin
         state_d.susp = 1'b1;
      end
      if (!low_power && state_q.susp) begin
         state_d.susp = 1'b0;
         if (!state_q.prio) begin
            state_d.busy = '0;
         end
      end
      if (stop_exit_reset) begin
         state_d.busy = '0;
         state_d.susp = 1'b0;
      end

      if (state_q.stall != 2'h0 && state_q.st == ST_IDLE) begin
         state_d.stall = state_q.stall - 2'h1;
      end

      unique case (state_q.st)
         ST_IDLE: begin
            state_d.bus.own = 1'b0;
            // interrupt taken at a byte boundary with priority clear disables the engine
            if (!state_q.prio && cpu_irq_req && any_run) begin
               state_d.te = '0;
            end else if (!hold && any_run) begin
               state_d.st = ST_RD;
               state_d.ch = pick;
               state_d.bus.own = 1'b1;
               state_d.bus.rd = 1'b1;
               state_d.bus.addr = src_a;
               state_d.brk_hit = (src_a == brk_addr);
            end
         end
         ST_RD: begin
            state_d.st = ST_WR;
            state_d.bus.wr = 1'b1;
            state_d.bus.addr = dst_a;
            state_d.bus.wdata = bus_rdata;
            state_d.brk_hit = (dst_a == brk_addr);
         end
         ST_WR: begin
            state_d.cnt[state_q.ch] = cnt_nx;
            state_d.gap = bw_gap(state_q.bw);
            if (blk_end) begin
               state_d.cnt[state_q.ch] = 8'h00;
               state_d.busy[state_q.ch] = 1'b0;
               state_d.swi[state_q.ch] = 1'b0;
               if (!state_q.loop[state_q.ch]) begin
                  state_d.te[state_q.ch] = 1'b0;
               end
               if (busy_cnt >= 2'h2 && bw_gap(state_q.bw) == GAP_BW3) begin
                  state_d.gap = GAP_BLOCK_MIN;
               end
            end
            if (word_go || burst_go) begin
               state_d.st = ST_RD;
               state_d.bus.rd = 1'b1;
               state_d.bus.addr = next_src;
               state_d.brk_hit = (next_src == brk_addr);
            end else if (state_d.gap > 3'h1) begin
               // the arbitration cycle in idle is the last processor cycle of the gap
               state_d.st = ST_GAP;
               state_d.gap = state_d.gap - 3'h1;
               state_d.bus.own = 1'b0;
            end else begin
               state_d.st = ST_IDLE;
               state_d.bus.own = 1'b0;
            end
         end
         ST_GAP: begin
            state_d.gap = state_q.gap - 3'h1;
            if (state_q.gap == 3'h1) begin
               state_d.st = ST_IDLE;
            end
         end
      endcase

      // hardware set wins over a clear in the same cycle
      if (state_q.st == ST_WR && blk_end) begin
         state_d.done[state_q.ch] = 1'b1;
      end
      state_d.irq = state_d.done & state_d.ie;
      state_d.irq_allow = !(state_q.prio && any_run);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign apb_rsp = state_q.rsp;
   assign bus_out = state_q.bus;
   assign brk_hit = state_q.brk_hit;
   assign chan_irq = state_q.irq;
   assign cpu_irq_allow = state_q.irq_allow;

endmodule

// [include/tcdma_pkg.sv]
// constants, register map and carrier types of the three-channel dma bus controller
package tcdma_pkg;
   localparam int NUM_CH = 3;

   // register byte addresses
   localparam logic [7:0] A_GCTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_SWINIT = 8'h08;
   localparam logic [7:0] A_BRKCTL = 8'h0C;
   localparam logic [7:0] A_CH_FIRST = 8'h10;
   localparam logic [7:0] A_CH_LAST = 8'h3C;
   // register within a channel block, paddr[3:2]
   localparam logic [1:0] CH_SRC = 2'h0;
   localparam logic [1:0] CH_DST = 2'h1;
   localparam logic [1:0] CH_CTL = 2'h2;
   localparam logic [1:0] CH_BLEN = 2'h3;

   // global control fields
   localparam int GC_TE_LSB = 0;
   localparam int GC_IE_LSB = 3;
   localparam int GC_BW_LSB = 6;
   // status and control fields
   localparam int ST_DONE_LSB = 0;
   localparam int ST_LOOP_LSB = 3;
   localparam int ST_WRE_BIT = 6;
   localparam int ST_PRIO_BIT = 7;
   // channel control fields; byte count reads back above them
   localparam int CC_SRC_LSB = 0;
   localparam int CC_DST_LSB = 2;
   localparam int CC_WORD_BIT = 4;
   localparam int CC_CNT_LSB = 8;
   localparam int BC_BCE_BIT = 0;

   // address modes
   localparam logic [1:0] MODE_STATIC = 2'h0;
   localparam logic [1:0] MODE_INC = 2'h1;
   localparam logic [1:0] MODE_DEC = 2'h2;

   // processor cycles granted after each device byte, by bandwidth code
   localparam logic [2:0] GAP_BW0 = 3'h6;
   localparam logic [2:0] GAP_BW1 = 3'h2;
   localparam logic [2:0] GAP_BW2 = 3'h1;
   localparam logic [2:0] GAP_BW3 = 3'h0;
   localparam logic [2:0] GAP_BLOCK_MIN = 3'h1;
   // channel register write latency in bus cycles
   localparam logic [1:0] LAT_DISABLED = 2'h2;
   localparam logic [1:0] LAT_ENABLED = 2'h3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RD = 2'b01,
      ST_WR = 2'b10,
      ST_GAP = 2'b11
   } tcdma_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } tcdma_apb_req_s;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } tcdma_apb_rsp_s;

   typedef struct packed {
      logic own;
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } tcdma_bus_s;
endpackage

// [verif/tcdma_asserts.sv]
// concurrent checks on the top-level ports of the dma controller
`timescale 1ns/1ps
module tcdma_asserts import tcdma_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register bus
   input wire tcdma_apb_req_s apb_req,
   input wire tcdma_apb_rsp_s apb_rsp,
   // shared bus, processor and break status
   input wire tcdma_bus_s bus_out,
   input wire logic [7:0] bus_rdata,
   input wire logic cpu_stop,
   input wire logic brk_active,
   input wire logic [15:0] brk_addr,
   input wire logic brk_hit
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_move;
      bus_out.rd ##1 (bus_out.wr && bus_out.own);
   endsequence
   sequence s_shown;
      (bus_out.rd || bus_out.wr) && bus_out.addr == brk_addr;
   endsequence
   property p_rd_wr;
      bus_out.rd |-> s_move;
   endproperty
   a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
   property p_wdata;
      bus_out.rd |=> bus_out.wdata == $past(bus_rdata);
   endproperty
   a_wdata: assert property (p_wdata) else $error("written byte differs from byte read");
   property p_own_start;
      $rose(bus_out.own) |-> bus_out.rd;
   endproperty
   a_own_start: assert property (p_own_start) else $error("bus taken without a read");
   property p_stop;
      (cpu_stop && !bus_out.own) |=> !bus_out.rd;
   endproperty
   a_stop: assert property (p_stop) else $error("byte started in stop");
   property p_brk;
      (brk_active && !bus_out.own) |=> !bus_out.rd;
   endproperty
   a_brk: assert property (p_brk) else $error("byte started in break");
   property p_hit;
      s_shown |-> brk_hit;
   endproperty
   a_hit: assert property (p_hit) else $error("break address missed");
   property p_hit_only;
      brk_hit |-> s_shown;
   endproperty
   a_hit_only: assert property (p_hit_only) else $error("spurious break hit");
   property p_rdy;
      (apb_req.psel && !apb_req.penable) |=> apb_rsp.pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("register access stalled");
   property p_err;
      (apb_rsp.pready && apb_req.paddr > 8'h3F) |-> apb_rsp.pslverr;
   endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule

// [verif/tcdma_bus_model.sv]
// shared-bus memory that answers engine reads in the same cycle
`timescale 1ns/1ps
module tcdma_bus_model import tcdma_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // engine side
   input wire tcdma_bus_s bus_out,
   output logic [7:0] bus_rdata
);
   logic [7:0] junk_q;
   // outside a read the lines churn, so a late sample cannot match by luck
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         junk_q <= 8'h00;
      end else begin
         junk_q <= junk_q + 8'h3B;
      end
   end
   assign bus_rdata = bus_out.rd ? (bus_out.addr[7:0] ^ bus_out.addr[15:8] ^ 8'h5A) : junk_q;
endmodule

// [verif/tb.sv]
// self-checking bench for the three-channel dma controller
`timescale 1ns/1ps
module tb import tcdma_pkg::*;;
   logic clk_sys, rst, cpu_wait, cpu_stop, stop_exit_reset, cpu_irq_req, cpu_irq_allow, brk_active, brk_hit, perr;
   tcdma_apb_req_s apb_req;
   tcdma_apb_rsp_s apb_rsp;
   tcdma_bus_s bus_out;
   logic [7:0] bus_rdata;
   logic [NUM_CH-1:0] svc_req, chan_irq;
   logic [15:0] brk_addr;
   logic [15:0] rq[$], wq[$];
   logic [7:0] wd[$];
   logic [2:0] gap [4];
   int rt[$];
   int failures, num_checks, cyc, hits;
   tcdma_top u_dut (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .bus_out(bus_out),
      .bus_rdata(bus_rdata), .svc_req(svc_req), .cpu_wait(cpu_wait), .cpu_stop(cpu_stop),
      .stop_exit_reset(stop_exit_reset), .cpu_irq_req(cpu_irq_req), .cpu_irq_allow(cpu_irq_allow),
      .brk_active(brk_active), .brk_addr(brk_addr), .brk_hit(brk_hit), .chan_irq(chan_irq));
   tcdma_bus_model u_bus (.clk_sys(clk_sys), .rst(rst), .bus_out(bus_out), .bus_rdata(bus_rdata));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (bus_out.rd === 1'b1) begin
         rq.push_back(bus_out.addr);
         rt.push_back(cyc);
      end
      if (bus_out.wr === 1'b1) begin
         wq.push_back(bus_out.addr);
         wd.push_back(bus_out.wdata);
      end
      if (brk_hit === 1'b1) hits <= hits + 1;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
   task results();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_sys);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (apb_rsp.pready !== 1'b1) failures++;
      q = apb_rsp.prdata;
      perr = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      check(q, e);
   endtask
   task chan(input int c, input logic [15:0] s, input logic [15:0] d, input logic [7:0] ctl, input logic [7:0] len);
      logic [7:0] b;
      b = A_CH_FIRST + 8'(c * 16);
      wr(b, {16'h0, s});
      wr(b + 8'h04, {16'h0, d});
      wr(b + 8'h08, {24'h0, ctl});
      wr(b + 8'h0C, {24'h0, len});
      rq.delete();
      rt.delete();
      wq.delete();
      wd.delete();
   endtask
   // the monitor pushes on the same edge, so settle a few cycles before looking
   task wait_wr(input int n);
      int k;
      k = 0;
      while (wq.size() < n && k < 400) begin
         @(posedge clk_sys);
         k++;
      end
      if (wq.size() < n) failures++;
      repeat (3) @(posedge clk_sys);
   endtask
   function automatic logic [15:0] off(input logic [1:0] m, input int i, input logic w);
      if (m == MODE_INC) return 16'(i);
      if (m == MODE_DEC) return 16'(-i);
      return w ? 16'(i % 2) : 16'h0;
   endfunction
   task verify(input logic [15:0] s, input logic [15:0] d, input logic [7:0] ctl, input int n);
      logic [15:0] sa;
      check(32'(wq.size()), 32'(n));
      for (int i = 0; i < n && i < wq.size(); i++) begin
         sa = s + off(ctl[1:0], i, ctl[4]);
         check({16'h0, rq[i]}, {16'h0, sa});
         check({16'h0, wq[i]}, {16'h0, d + off(ctl[3:2], i, ctl[4])});
         check({24'h0, wd[i]}, {24'h0, sa[7:0] ^ sa[15:8] ^ 8'h5A});
      end
   endtask
   task start(input logic [31:0] gc, input logic [31:0] sw);
      wr(A_GCTRL, gc);
      wr(A_SWINIT, sw);
   endtask
   initial begin
      rst = 1'b1;
      apb_req = '0;
      svc_req = '0;
      {cpu_wait, cpu_stop, stop_exit_reset, cpu_irq_req, brk_active} = 5'h00;
      brk_addr = 16'h6001;
      gap = '{GAP_BW0, GAP_BW1, GAP_BW2, GAP_BW3};
      failures = 0;
      num_checks = 0;
      cyc = 0;
      hits = 0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rd(A_GCTRL, 32'h0);
      rd(8'h40, 32'h0);
      check({31'h0, perr}, 32'h1);
      $display("reset test done");
      chan(0, 16'h1000, 16'h2000, 8'h05, 8'h04);
      start(32'hC9, 32'h1);
      wait_wr(4);
      verify(16'h1000, 16'h2000, 8'h05, 4);
      check({29'h0, chan_irq}, 32'h1);
      rd(A_GCTRL, 32'hC8);
      rd(A_CH_FIRST + 8'h08, 32'h05);
      rd(A_STAT, 32'h1);
      wr(A_STAT, 32'h0);
      rd(A_STAT, 32'h0);
      chan(1, 16'h3000, 16'h0001, 8'h18, 8'h04);
      start(32'hC2, 32'h2);
      wait_wr(4);
      verify(16'h3000, 16'h0001, 8'h18, 4);
      check({29'h0, chan_irq}, 32'h0);
      $display("address test done");
      for (int bw = 0; bw < 4; bw++) begin
         chan(2, 16'h4000, 16'h5000, 8'h06, 8'h02);
         start({24'h0, 2'(bw), 6'h04}, 32'h4);
         wait_wr(2);
         check(32'(rt[1] - rt[0]), 32'(gap[bw]) + 32'h2);
         verify(16'h4000, 16'h5000, 8'h06, 2);
      end
      chan(0, 16'h1000, 16'h2000, 8'h05, 8'h01);
      chan(1, 16'h3000, 16'h4000, 8'h05, 8'h01);
      start(32'hC3, 32'h3);
      wait_wr(2);
      check({16'h0, rq[0]}, 32'h1000);
      check(32'(rt[1] - rt[0]), 32'h3);
      $display("bandwidth test done");
      chan(0, 16'h1000, 16'h2000, 8'h05, 8'h02);
      wr(A_STAT, 32'h80);
      cpu_stop <= 1'b1;
      start(32'hC1, 32'h1);
      repeat (20) @(posedge clk_sys);
      check(32'(rq.size()), 32'h0);
      check({31'h0, cpu_irq_allow}, 32'h0);
      cpu_stop <= 1'b0;
      wait_wr(2);
      check(32'(wq.size()), 32'h2);
      wr(A_GCTRL, 32'hC0);
      chan(0, 16'h1000, 16'h2000, 8'h05, 8'h02);
      cpu_stop <= 1'b1;
      wr(A_GCTRL, 32'hC1);
      svc_req <= 3'h1;
      @(posedge clk_sys);
      svc_req <= 3'h0;
      repeat (5) @(posedge clk_sys);
      stop_exit_reset <= 1'b1;
      @(posedge clk_sys);
      stop_exit_reset <= 1'b0;
      cpu_stop <= 1'b0;
      repeat (30) @(posedge clk_sys);
      check(32'(rq.size()), 32'h0);
      $display("stop test done");
      wr(A_STAT, 32'h40);
      chan(0, 16'h1000, 16'h2000, 8'h05, 8'h02);
      cpu_wait <= 1'b1;
      start(32'hC1, 32'h1);
      wait_wr(2);
      check(32'(wq.size()), 32'h2);
      wr(A_STAT, 32'h80);
      chan(0, 16'h1000, 16'h2000, 8'h05, 8'h02);
      start(32'hC1, 32'h1);
      repeat (20) @(posedge clk_sys);
      check(32'(rq.size()), 32'h0);
      cpu_wait <= 1'b0;
      wait_wr(2);
      check(32'(wq.size()), 32'h2);
      $display("wait test done");
      wr(A_STAT, 32'h0);
      chan(0, 16'h1000, 16'h6000, 8'h05, 8'h02);
      brk_active <= 1'b1;
      start(32'hC1, 32'h1);
      repeat (20) @(posedge clk_sys);
      check(32'(rq.size()), 32'h0);
      brk_active <= 1'b0;
      wait_wr(2);
      check(32'(hits), 32'h1);
      brk_active <= 1'b1;
      rd(A_STAT, 32'h07);
      wr(A_STAT, 32'h0);
      rd(A_STAT, 32'h07);
      wr(A_BRKCTL, 32'h1);
      rd(A_STAT, 32'h07);
      wr(A_STAT, 32'h0);
      brk_active <= 1'b0;
      rd(A_STAT, 32'h0);
      $display("break test done");
      chan(0, 16'h1000, 16'h2000, 8'h05, 8'h08);
      check({31'h0, cpu_irq_allow}, 32'h1);
      start(32'h01, 32'h1);
      cpu_irq_req <= 1'b1;
      repeat (3) @(posedge clk_sys);
      cpu_irq_req <= 1'b0;
      rd(A_GCTRL, 32'h00);
      check(32'(rq.size()), 32'h0);
      $display("interrupt test done");
      results();
   end
endmodule
bind tcdma_top tcdma_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .bus_out(bus_out), .bus_rdata(bus_rdata), .cpu_stop(cpu_stop), .brk_active(brk_active),
   .brk_addr(brk_addr), .brk_hit(brk_hit));
